// file: design/reduced_power_mode_control.sv
// reduced power mode controller: idle, power-down and standby clock gating
`timescale 1ns/1ps
module reduced_power_mode_control
  import pwr_pkg::*;
#(
  parameter int unsigned reset_hold_cycles = idle_reset_cycles
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic power_control_wr,
  input wire logic [7:0] power_control_wdata,
  input wire logic rom_bank_wr,
  input wire logic [7:0] rom_bank_wdata,
  input wire logic watchdog_key_wr,
  input wire logic [7:0] watchdog_key_wdata,
  input wire logic wdog_enable_wr,
  input wire logic irq_pending,
  input wire logic ext_irq_level_n,
  input wire logic ext_irq_level_mode,
  input wire logic sadc_cmp_irq,
  input wire logic sadc_wake_en,
  output logic [7:0] power_control_reg,
  output logic [7:0] rom_bank_reg,
  output logic wdog_active,
  output logic cpu_hold,
  output logic display_mem_init,
  output logic [15:0] pc_load_value,
  output logic pc_load,
  output mode_e mode,
  output sect_en_s sect_en,
  output logic clk_cpu,
  output logic clk_acq,
  output logic clk_disp,
  output logic clk_periph
);
  mode_e mode_q, mode_d;
  logic [7:0] power_control_q, power_control_d;
  logic [7:0] rom_bank_q;
  logic wdog_q;
  logic init_q;
  logic wake_idle, wake_powerdown, standby, writable, sadc_wake;

  // power control and rom bank writes only land while running; watchdog writes land in any mode
  assign writable = (mode_q == st_run);

  // wake sources per mode
  assign sadc_wake = sadc_wake_en & sadc_cmp_irq;
  assign wake_idle = irq_pending | sadc_wake;
  assign wake_powerdown = (ext_irq_level_mode & ~ext_irq_level_n) | sadc_wake;
  assign standby = rom_bank_q[standby_bit_pos];

  // mode next state, wake wins over software write
  always_comb begin
    mode_d = mode_q;
    power_control_d = power_control_q;
    if (power_control_wr && writable) begin
      power_control_d = power_control_wdata;
    end
    case (mode_q)
      st_run: begin
        if (power_control_d[powerdown_bit_pos]) begin
          mode_d = st_powerdown;
        end else if (power_control_d[sleep_bit_pos]) begin
          mode_d = st_idle;
        end
      end
      st_idle: begin
        if (wake_idle) begin
          mode_d = st_run;
          power_control_d[sleep_bit_pos] = 1'b0;
        end
      end
      st_powerdown: begin
        if (wake_powerdown) begin
          mode_d = st_run;
          power_control_d[powerdown_bit_pos] = 1'b0;
          power_control_d[sleep_bit_pos] = 1'b0; // no idle re-entry after a double request
        end
      end
      default: mode_d = st_run;
    endcase
  end

  // state registers; reset restores registers, keeps nothing else here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= st_run;
      power_control_q <= power_control_rst;
      rom_bank_q <= rom_bank_rst;
      wdog_q <= 1'b0;
      init_q <= 1'b1;
    end else if (clk_en) begin
      mode_q <= mode_d;
      power_control_q <= power_control_d;
      init_q <= 1'b0;
      if (rom_bank_wr && writable) begin
        rom_bank_q <= rom_bank_wdata;
      end
      if (wdog_enable_wr) begin
        wdog_q <= 1'b1;
      end else if (watchdog_key_wr && watchdog_key_wdata == watchdog_disable_key) begin
        wdog_q <= 1'b0;
      end
    end
  end

  // section enables
  assign sect_en.osc = (mode_q != st_powerdown);
  assign sect_en.cpu = (mode_q == st_run);
  assign sect_en.acq = (mode_q == st_run) & ~standby;
  assign sect_en.disp = (mode_q == st_run) & ~standby;
  assign sect_en.mem = (mode_q != st_powerdown);
  assign sect_en.i2c = (mode_q != st_powerdown);
  assign sect_en.timer = (mode_q != st_powerdown);
  assign sect_en.wdog = (mode_q != st_powerdown);
  assign sect_en.pwm = (mode_q != st_powerdown);
  assign sect_en.sadc = (mode_q == st_run);

  // outputs
  assign power_control_reg = power_control_q;
  assign rom_bank_reg = rom_bank_q;
  assign wdog_active = wdog_q;
  assign mode = mode_q;
  assign cpu_hold = (mode_q != st_run);
  assign display_mem_init = init_q;
  assign pc_load = init_q;
  assign pc_load_value = reset_vector;

  // gated section clocks, latch gates keep every pulse whole
  clk_gate_cell u_gate_cpu (.clk(clk), .en(sect_en.cpu & clk_en), .gclk(clk_cpu));
  clk_gate_cell u_gate_acq (.clk(clk), .en(sect_en.acq & clk_en), .gclk(clk_acq));
  clk_gate_cell u_gate_disp (.clk(clk), .en(sect_en.disp & clk_en), .gclk(clk_disp));
  clk_gate_cell u_gate_per (.clk(clk), .en(sect_en.mem & clk_en), .gclk(clk_periph));

  // reset-hold counter for checks only
  logic [7:0] rst_cnt_q;
  always_ff @(posedge clk) begin
    if (!sys_rst) begin
      rst_cnt_q <= 8'h00;
    end else if (rst_cnt_q != 8'hff) begin
      rst_cnt_q <= rst_cnt_q + 8'h01;
    end
  end

  // mode entry and wake checks
  chk_idle_entry: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_q == st_run && power_control_wr && power_control_wdata[sleep_bit_pos]
      && !power_control_wdata[powerdown_bit_pos]) |=> mode_q == st_idle)
    else $error("idle not entered");
  chk_powerdown_entry: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_q == st_run && power_control_wr && power_control_wdata[powerdown_bit_pos])
    |=> mode_q == st_powerdown) else $error("power-down not entered");
  chk_idle_wake: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_q == st_idle && wake_idle) |=> (mode_q == st_run && !power_control_q[sleep_bit_pos]))
    else $error("idle wake failed");
  chk_compare_idle_wake: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_q == st_idle && sadc_wake_en && sadc_cmp_irq) |=> mode_q == st_run)
    else $error("compare wake from idle failed");
  chk_powerdown_wake: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_q == st_powerdown && ext_irq_level_mode && !ext_irq_level_n) |=> mode_q == st_run)
    else $error("power-down wake failed");
  chk_compare_powerdown_wake: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_q == st_powerdown && sadc_wake_en && sadc_cmp_irq) |=> mode_q == st_run)
    else $error("compare wake from power-down failed");
  chk_powerdown_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_q == st_powerdown && !(ext_irq_level_mode && !ext_irq_level_n) && !(sadc_wake_en && sadc_cmp_irq))
    |=> mode_q == st_powerdown) else $error("power-down left without wake");

  // section gating checks
  chk_idle_gating: assert property (@(posedge clk) disable iff (sys_rst)
    mode_q == st_idle |-> (!sect_en.cpu && !sect_en.acq && !sect_en.disp && sect_en.osc && sect_en.timer))
    else $error("idle gating wrong");
  chk_idle_kept: assert property (@(posedge clk) disable iff (sys_rst)
    mode_q == st_idle |-> (sect_en.mem && sect_en.i2c && sect_en.timer && sect_en.wdog && sect_en.pwm))
    else $error("idle peripheral clock lost");
  chk_powerdown_osc: assert property (@(posedge clk) disable iff (sys_rst)
    mode_q == st_powerdown |-> !sect_en.osc && !sect_en.mem) else $error("power-down oscillator running");
  chk_standby_gate: assert property (@(posedge clk) disable iff (sys_rst)
    standby |-> !sect_en.acq && !sect_en.disp) else $error("standby gating wrong");
  chk_standby_run: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_q == st_run && standby) |-> (sect_en.cpu && sect_en.mem && sect_en.i2c && sect_en.timer
      && sect_en.wdog && sect_en.sadc && sect_en.pwm)) else $error("standby stopped a live section");
  chk_standby_set: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && mode_q == st_run && rom_bank_wr && rom_bank_wdata[standby_bit_pos]) |=> standby)
    else $error("standby not entered");
  chk_standby_keep: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_q != st_run && standby) |=> standby) else $error("standby lost");

  // register checks
  chk_wdog_key: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(wdog_q) && !$past(sys_rst))
    |-> $past(watchdog_key_wr) && $past(watchdog_key_wdata) == watchdog_disable_key)
    else $error("watchdog disabled without key");
  chk_reset_init: assert property (@(posedge clk)
    (rst_cnt_q >= 8'h02) |-> (mode_q == st_run && power_control_q == power_control_rst
      && rom_bank_q == rom_bank_rst && init_q))
    else $error("reset init wrong");
  chk_freeze_control: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_q == st_idle && !wake_idle) |=> $stable(power_control_q)) else $error("idle state changed");
  chk_bank_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    mode_q != st_run |=> $stable(rom_bank_q)) else $error("bank register changed while saving");

  // main scenarios
  cov_idle: cover property (@(posedge clk) mode_q == st_idle ##1 mode_q == st_run);
  cov_powerdown: cover property (@(posedge clk) mode_q == st_powerdown ##1 mode_q == st_run);
  cov_standby_idle: cover property (@(posedge clk) standby && mode_q == st_idle);
  cov_wdog_off: cover property (@(posedge clk) $fell(wdog_q));
  cov_reset_hold: cover property (@(posedge clk) rst_cnt_q == 8'(reset_hold_cycles));
endmodule

// file: design/pwr_pkg.sv
// package: power mode constants and section enable struct
package pwr_pkg;
  localparam int unsigned clk_rate_hz = 10_000_000;
  localparam int unsigned clk_period_ns = 100;
  // power control register field positions, standby bit in the rom bank register
  localparam int unsigned sleep_bit_pos = 0;
  localparam int unsigned powerdown_bit_pos = 1;
  localparam int unsigned standby_bit_pos = 7;
  localparam logic [7:0] power_control_rst = 8'h00;
  localparam logic [7:0] rom_bank_rst = 8'h00;
  localparam logic [7:0] watchdog_disable_key = 8'h55;
  localparam logic [15:0] reset_vector = 16'h0000;
  // oscillator clocks per machine cycle and cycles of reset in idle
  localparam int unsigned clocks_per_machine_cycle = 12;
  localparam int unsigned idle_reset_machine_cycles = 2;
  localparam int unsigned idle_reset_cycles = clocks_per_machine_cycle * idle_reset_machine_cycles;

  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_idle = 2'b01,
    st_powerdown = 2'b10
  } mode_e;

  // one enable per clocked section
  typedef struct packed {
    logic osc;
    logic cpu;
    logic acq;
    logic disp;
    logic mem;
    logic i2c;
    logic timer;
    logic wdog;
    logic pwm;
    logic sadc;
  } sect_en_s;
endpackage

// file: design/clk_gate_cell.sv
// glitch free clock gate cell
`timescale 1ns/1ps
module clk_gate_cell (
  input wire logic clk,
  input wire logic en,
  output logic gclk
);
  logic en_latch;

  // latch enable while clock low so pulses are never cut
  always_latch begin
    if (!clk) begin
      en_latch <= en;
    end
  end

  assign gclk = clk & en_latch;
endmodule

// file: sim/tb.sv
// testbench: power mode controller scenarios
`timescale 1ns/1ps
module tb;
  import pwr_pkg::*;
  logic clk = 0, sys_rst = 1, clk_en = 1, power_control_wr = 0, rom_bank_wr = 0, watchdog_key_wr = 0;
  logic wdog_enable_wr = 0;
  logic irq_pending = 0, ext_irq_level_n = 1, ext_irq_level_mode = 0, sadc_cmp_irq = 0, sadc_wake_en = 0;
  logic [7:0] power_control_wdata = 8'h00, rom_bank_wdata = 8'h00, watchdog_key_wdata = 8'h00;
  logic [7:0] power_control_reg, rom_bank_reg;
  logic [15:0] pc_load_value;
  logic wdog_active, cpu_hold, display_mem_init, pc_load, clk_cpu, clk_acq, clk_disp, clk_periph;
  mode_e mode;
  sect_en_s sect_en;
  int error_cnt = 0, samples_checked = 0, cyc = 0, ncpu = 0, nper = 0, nacq = 0, ndsp = 0, a = 0, b = 0;
  always #50 clk = ~clk;
  // rising edge counters on gated clocks
  always @(posedge clk_cpu) ncpu++;
  always @(posedge clk_periph) nper++;
  always @(posedge clk_acq) nacq++;
  always @(posedge clk_disp) ndsp++;
  reduced_power_mode_control reduced_power_mode_control_i (.clk, .sys_rst, .clk_en, .power_control_wr,
    .power_control_wdata, .rom_bank_wr, .rom_bank_wdata, .watchdog_key_wr, .watchdog_key_wdata,
    .wdog_enable_wr, .irq_pending, .ext_irq_level_n, .ext_irq_level_mode, .sadc_cmp_irq, .sadc_wake_en,
    .power_control_reg, .rom_bank_reg, .wdog_active, .cpu_hold, .display_mem_init, .pc_load_value, .pc_load,
    .mode, .sect_en, .clk_cpu, .clk_acq, .clk_disp, .clk_periph);
  task automatic final_report;
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle write strobe: 0 power control, 1 rom bank, 2 watchdog key
  task automatic wr(input int sel, input logic [7:0] d);
    @(negedge clk);
    power_control_wr = (sel == 0);
    rom_bank_wr = (sel == 1);
    watchdog_key_wr = (sel == 2);
    power_control_wdata = d;
    rom_bank_wdata = d;
    watchdog_key_wdata = d;
    @(negedge clk);
    {power_control_wr, rom_bank_wr, watchdog_key_wr} = 3'h0;
  endtask
  task automatic t_reset;
    chk(16'(display_mem_init), 16'h0001);
    chk(pc_load_value, 16'h0000);
    chk(16'({power_control_reg, rom_bank_reg}), 16'h0000);
    sys_rst = 0;
    cyc_n(1);
    chk(16'(pc_load), 16'h0000);
  endtask
  task automatic t_idle;
    chk(16'(wdog_active), 16'h0000);
    wr(0, 8'h01);
    chk(16'(mode), 16'(st_idle));
    chk(16'({cpu_hold, power_control_reg}), 16'h0101);
    chk(16'(sect_en), 16'h023e);
    a = ncpu;
    b = nper;
    wr(1, 8'h80);
    cyc_n(2);
    chk(16'(ncpu - a), 16'h0000);
    chk(16'(nper - b), 16'h0004);
    chk(16'(rom_bank_reg), 16'h0000);
    irq_pending = 1;
    cyc_n(1);
    irq_pending = 0;
    chk(16'({8'(mode), power_control_reg}), 16'h0000);
    chk(16'(sect_en), 16'h03ff);
  endtask
  task automatic t_sadc(input logic [7:0] d, input mode_e m);
    wr(0, d);
    sadc_cmp_irq = 1;
    cyc_n(1);
    chk(16'(mode), 16'(m));
    sadc_wake_en = 1;
    cyc_n(1);
    chk(16'({8'(mode), power_control_reg}), 16'h0000);
    {sadc_cmp_irq, sadc_wake_en} = 2'b00;
  endtask
  task automatic t_powerdown;
    wr(0, 8'h02);
    chk(16'({8'(mode), power_control_reg}), 16'h0202);
    chk(16'({sect_en.osc, sect_en.cpu}), 16'h0000);
    ext_irq_level_n = 0;
    cyc_n(1);
    chk(16'(mode), 16'(st_powerdown));
    ext_irq_level_mode = 1;
    cyc_n(1);
    chk(16'({8'(mode), power_control_reg}), 16'h0000);
    {ext_irq_level_n, ext_irq_level_mode} = 2'b10;
  endtask
  task automatic t_standby;
    wr(1, 8'h80);
    chk(16'(sect_en), 16'h033f);
    a = nacq;
    b = ndsp;
    wr(0, 8'h01);
    chk(16'(sect_en), 16'h023e);
    irq_pending = 1;
    cyc_n(1);
    irq_pending = 0;
    chk(16'({rom_bank_reg, 8'(mode)}), 16'h8000);
    chk(16'(sect_en), 16'h033f);
    chk(16'({8'(nacq - a), 8'(ndsp - b)}), 16'h0000);
    wr(1, 8'h00);
    a = nacq;
    b = ndsp;
    cyc_n(2);
    chk(16'({8'(nacq - a), 8'(ndsp - b)}), 16'h0202);
  endtask
  // low clock enable freezes state and gated clocks, writes included
  task automatic t_hold;
    @(negedge clk);
    clk_en = 0;
    a = ncpu;
    wr(0, 8'h01);
    chk(16'({8'(mode), power_control_reg}), 16'h0000);
    chk(16'(ncpu - a), 16'h0000);
    clk_en = 1;
  endtask
  task automatic t_wdog;
    @(negedge clk) wdog_enable_wr = 1;
    @(negedge clk) wdog_enable_wr = 0;
    chk(16'(wdog_active), 16'h0001);
    wr(2, 8'h54);
    chk(16'(wdog_active), 16'h0001);
    wr(2, watchdog_disable_key);
    chk(16'(wdog_active), 16'h0000);
  endtask
  task automatic t_rst_idle;
    chk(16'(wdog_active), 16'h0000);
    wr(0, 8'h01);
    sys_rst = 1;
    cyc_n(24);
    chk(16'(display_mem_init), 16'h0001);
    sys_rst = 0;
    cyc_n(1);
    chk(16'({8'(mode), power_control_reg}), 16'h0000);
  endtask
  // cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    cyc_n(10);
    t_reset;
    t_idle;
    t_sadc(8'h01, st_idle);
    t_sadc(8'h02, st_powerdown);
    t_powerdown;
    t_standby;
    t_hold;
    t_wdog;
    t_rst_idle;
    final_report;
  end
endmodule
